// ==== design/lxs_status_regs.sv ====
// Purpose: Status, mask and information registers of the line transceiver
// Assumes: Host strobes are one-cycle, synchronous to clock_i
// Notes:   Read data and interrupt are registered
//
// Function
// - Mask bit 0 blocks its source from interrupting; 1 lets it through.
// - FIFO condition bits interrupt only on their rising transition.
// - Transmit store overfill with dropped frame sets bit 5.
// - Transmit store run-dry with repeated frame sets bit 4.
// - Any transmit store slip sets bit 3.
// - Receive store: overfill bit 2, run-dry bit 1, any slip bit 0.
// - Message-end event bit 6 latched on send completion, cleared on read.
// - Packet-end bit 5 on good end, CRC error, overrun or abort.
// - Packet-start bit 4 latched on opening byte, cleared on read.
// - Bit 3 live while receive FIFO exceeds high mark.
// - Bit 2 while receive FIFO not empty; bit 0 while transmit has room.
// - Bit 1 live while transmit FIFO below low mark.
// - Info bits 5,4,3: transmit empty, transmit full, receive empty, live.
// - Bits 2..0 give packet status of last receive FIFO read.
// - Seven ones abort a packet; full receive FIFO ends with overrun.
// - Transmit FIFO empty before end mark: send abort, latch underrun.
// - Opening-byte event when next readable byte starts a message.
// - Code-clear event after 30 link bits without abort.
// - Link abort event after eight consecutive ones.
// - Link receive buffer full bit 3; transmit buffer empty bit 2.
// - Link match event when received byte equals either match value.
// - Code-change event bit 0; host then reads the received link byte.
`timescale 1ns/10ps
`include "lxs_defines.svh"

module lxs_status_regs (
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    input  wire logic                    cs_i,
    input  wire logic                    rd_i,
    input  wire logic                    wr_i,
    input  wire logic [7:0]              addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire lxs_pkg::lxs_store_s     store_i,
    input  wire lxs_pkg::lxs_hdlc_s [1:0] hdlc_i,
    input  wire lxs_pkg::lxs_link_s      link_i,
    output logic [7:0]                   rdata_o,
    output logic                         irq_o,
    output logic [1:0]                   tx_abort_o
);

    lxs_pkg::lxs_state_s s_q;
    lxs_pkg::lxs_state_s s_d;

    // Set wins over a clear arriving in the same cycle
    function automatic logic [7:0] keep_set(input logic [7:0] q,
                                            input logic [7:0] set,
                                            input logic       clr);
        return (clr ? `LXS_RST_BYTE : q) | set;
    endfunction

    // Live FIFO conditions: high mark, not empty, low mark, room
    function automatic logic [3:0] fifo_cond(input lxs_pkg::lxs_hdlc_s c);
        logic [3:0] r;
        r[3] = c.rx_count > c.rx_high_mark_setting;
        r[2] = c.rx_count != `LXS_FIFO_NONE;
        r[1] = c.tx_count < c.tx_low_mark_setting;
        r[0] = c.tx_count != `LXS_FIFO_DEPTH;
        return r;
    endfunction

    // Live info byte for one controller
    function automatic logic [7:0] info_byte(input lxs_pkg::lxs_hdlc_s c,
                                             input logic [2:0] ps);
        return {2'h0,
                c.tx_count == `LXS_FIFO_NONE,
                c.tx_count == `LXS_FIFO_DEPTH,
                c.rx_count == `LXS_FIFO_NONE,
                ps};
    endfunction

    logic       rd_hit;
    logic       wr_hit;
    logic [7:0] st_set;
    logic [7:0] lk_set;
    logic [3:0] inf_set;
    logic [3:0] cond;
    logic       abrt;
    logic       ovr;
    logic       pend_any;
    logic [7:0] rd_val;
    logic [2:0] hset;

    // Next-state logic for every register and counter
    always_comb begin
        s_d      = s_q;
        rd_hit   = cs_i && rd_i;
        wr_hit   = cs_i && wr_i;
        st_set   = `LXS_RST_BYTE;
        lk_set   = `LXS_RST_BYTE;
        inf_set  = 4'h0;
        cond     = 4'h0;
        abrt     = 1'b0;
        ovr      = 1'b0;
        hset     = 3'h0;
        pend_any = 1'b0;
        rd_val   = `LXS_RST_BYTE;
        s_d.tx_abort = 2'h0;

        // Elastic store slips
        st_set[`LXS_TX_FULL_BIT]  = store_i.tx_del;
        st_set[`LXS_TX_EMPTY_BIT] = store_i.tx_rep;
        st_set[`LXS_TX_SLIP_BIT]  = store_i.tx_del | store_i.tx_rep;
        st_set[`LXS_RX_FULL_BIT]  = store_i.rx_del;
        st_set[`LXS_RX_EMPTY_BIT] = store_i.rx_rep;
        st_set[`LXS_RX_SLIP_BIT]  = store_i.rx_del | store_i.rx_rep;
        s_d.store_stat = keep_set(s_q.store_stat, st_set,
            rd_hit && addr_i == `LXS_ADDR_STORE_STAT);

        // Facility data link: run of ones and bit window for code clear
        if (link_i.bit_en) begin
            if (!link_i.bit_val) begin
                s_d.link_ones = 4'h0;
            end else if (s_q.link_ones != `LXS_LINK_ABORT_ONES) begin
                s_d.link_ones = s_q.link_ones + 4'h1;
            end
            if (link_i.bit_val &&
                s_q.link_ones == `LXS_LINK_ABORT_ONES - 4'h1) begin
                lk_set[`LXS_LINK_ABORT_BIT] = 1'b1;
                s_d.link_bits = 5'h0;
            end else if (s_q.link_bits == `LXS_CODE_CLR_BITS - 5'h1) begin
                lk_set[`LXS_CODE_CLR_BIT] = 1'b1;
                s_d.link_bits = 5'h0;
            end else begin
                s_d.link_bits = s_q.link_bits + 5'h1;
            end
        end
        lk_set[`LXS_LINK_RXFULL_BIT]  = link_i.rx_byte_load;
        lk_set[`LXS_LINK_TXEMPTY_BIT] = link_i.tx_byte_taken;
        lk_set[`LXS_LINK_MATCH_BIT]   = link_i.rx_byte_load &&
            (link_i.link_rx_byte == link_i.link_match_value_a ||
             link_i.link_rx_byte == link_i.link_match_value_b);
        lk_set[`LXS_CODE_CHG_BIT] = link_i.code_change;
        s_d.link_stat = keep_set(s_q.link_stat, lk_set,
            rd_hit && addr_i == `LXS_ADDR_LINK_STAT);

        // Both HDLC controllers
        for (int i = 0; i < 2; i++) begin
            cond = fifo_cond(hdlc_i[i]);
            s_d.h[i].cond_prev = ~cond;  // Inverted: no edge out of reset
            // Receive bit run: seven ones end the packet as aborted
            abrt = 1'b0;
            if (hdlc_i[i].rx_bit_en) begin
                if (!hdlc_i[i].rx_bit) begin
                    s_d.h[i].ones = 3'h0;
                end else if (s_q.h[i].ones != `LXS_HDLC_ABORT_ONES) begin
                    s_d.h[i].ones = s_q.h[i].ones + 3'h1;
                end
                abrt = hdlc_i[i].rx_bit && s_q.h[i].in_pkt &&
                       s_q.h[i].ones == `LXS_HDLC_ABORT_ONES - 3'h1;
            end
            ovr = hdlc_i[i].rx_wr && s_q.h[i].in_pkt &&
                  hdlc_i[i].rx_count == `LXS_FIFO_DEPTH;
            if (hdlc_i[i].rx_start) begin
                s_d.h[i].in_pkt = 1'b1;
            end
            // Packet end: overrun beats abort beats CRC verdict
            if (s_q.h[i].in_pkt && (ovr || abrt ||
                hdlc_i[i].rx_crc_good || hdlc_i[i].rx_crc_bad)) begin
                s_d.h[i].in_pkt = 1'b0;
                s_d.h[i].ended  = 1'b1;
                s_d.h[i].end_code = ovr  ? `LXS_PS_OVERRUN :
                                    abrt ? `LXS_PS_ABORT :
                                    hdlc_i[i].rx_crc_bad ?
                                    `LXS_PS_CRC_ERR : `LXS_PS_GOOD;
            end
            hset[2] = hdlc_i[i].tx_msg_done;
            hset[1] = s_q.h[i].in_pkt && (ovr || abrt ||
                      hdlc_i[i].rx_crc_good || hdlc_i[i].rx_crc_bad);
            hset[0] = hdlc_i[i].rx_start;
            // Packet status follows each host pop of the receive FIFO
            if (hdlc_i[i].rx_rd) begin
                s_d.h[i].pkt_status = (hdlc_i[i].rx_rd_last &&
                    s_q.h[i].ended) ? s_q.h[i].end_code
                                    : `LXS_PS_BUSY;
                if (hdlc_i[i].rx_rd_last) begin
                    s_d.h[i].ended = 1'b0;
                end
            end
            // Underrun: transmitter starved before the end indication
            if (hdlc_i[i].tx_end_given || hdlc_i[i].tx_msg_done) begin
                s_d.h[i].in_msg = 1'b0;
            end else if (hdlc_i[i].tx_count != `LXS_FIFO_NONE) begin
                s_d.h[i].in_msg = 1'b1;
            end
            if (hdlc_i[i].tx_need && s_q.h[i].in_msg &&
                !hdlc_i[i].tx_end_given &&
                hdlc_i[i].tx_count == `LXS_FIFO_NONE) begin
                s_d.tx_abort[i]   = 1'b1;
                s_d.h[i].in_msg   = 1'b0;
                inf_set[2 * i + 1] = 1'b1;
            end
            s_d.h[i].first_prev = hdlc_i[i].rx_next_first;
            inf_set[2 * i] = hdlc_i[i].rx_next_first &&
                             !s_q.h[i].first_prev;
            // Latched events and rising-edge condition latches
            if (rd_hit && addr_i == (i == 0 ? `LXS_ADDR_H1_STAT
                                            : `LXS_ADDR_H2_STAT)) begin
                s_d.h[i].evt  = hset;
                s_d.h[i].pend = cond & s_q.h[i].cond_prev;
            end else begin
                s_d.h[i].evt  = s_q.h[i].evt | hset;
                s_d.h[i].pend = s_q.h[i].pend |
                                (cond & s_q.h[i].cond_prev);
            end
            if (wr_hit && addr_i == (i == 0 ? `LXS_ADDR_H1_MASK
                                            : `LXS_ADDR_H2_MASK)) begin
                s_d.h[i].mask = {1'b0, wdata_i[6:0]};
            end
            pend_any = pend_any |
                (|({s_q.h[i].evt, s_q.h[i].pend} & s_q.h[i].mask[6:0]));
        end
        s_d.info_evt = (rd_hit && addr_i == `LXS_ADDR_EVT_INFO) ?
                       inf_set : (s_q.info_evt | inf_set);

        // Mask writes; reserved bits stay zero
        if (wr_hit) begin
            unique case (addr_i)
                `LXS_ADDR_STORE_MASK: s_d.store_mask = {2'h0, wdata_i[5:0]};
                `LXS_ADDR_LINK_MASK:  s_d.link_mask  = {2'h0, wdata_i[5:0]};
                default: ;
            endcase
        end

        // Read mux; unmapped offsets return zero
        unique case (addr_i)
            `LXS_ADDR_STORE_STAT: rd_val = s_q.store_stat;
            `LXS_ADDR_STORE_MASK: rd_val = s_q.store_mask;
            `LXS_ADDR_H1_STAT: rd_val = {1'b0, s_q.h[0].evt,
                                         fifo_cond(hdlc_i[0])};
            `LXS_ADDR_H1_MASK:    rd_val = s_q.h[0].mask;
            `LXS_ADDR_H2_STAT: rd_val = {1'b0, s_q.h[1].evt,
                                         fifo_cond(hdlc_i[1])};
            `LXS_ADDR_H2_MASK:    rd_val = s_q.h[1].mask;
            `LXS_ADDR_LINK_STAT:  rd_val = s_q.link_stat;
            `LXS_ADDR_LINK_MASK:  rd_val = s_q.link_mask;
            `LXS_ADDR_EVT_INFO:   rd_val = {4'h0, s_q.info_evt};
            `LXS_ADDR_H1_INFO:
                rd_val = info_byte(hdlc_i[0], s_q.h[0].pkt_status);
            `LXS_ADDR_H2_INFO:
                rd_val = info_byte(hdlc_i[1], s_q.h[1].pkt_status);
            default:              rd_val = `LXS_RST_BYTE;
        endcase
        if (rd_hit) begin
            s_d.rdata = rd_val;
        end

        // Single request line; info events have no mask, so not wired in
        s_d.irq = pend_any ||
                  (|(s_q.store_stat & s_q.store_mask)) ||
                  (|(s_q.link_stat & s_q.link_mask));
    end

    // State register; synchronous reset clears everything
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_o    = s_q.rdata;
    assign irq_o      = s_q.irq;
    assign tx_abort_o = s_q.tx_abort;

endmodule

// ==== shared/lxs_defines.svh ====
// Purpose: Named offsets, bit positions and counts for the status block
// Assumes: 8-bit parallel host bus, byte offsets as printed
// Notes:   Definitions only
`ifndef LXS_DEFINES_SVH
`define LXS_DEFINES_SVH

// Register offsets
`define LXS_ADDR_STORE_STAT   8'h1e
`define LXS_ADDR_STORE_MASK   8'h1f
`define LXS_ADDR_H1_STAT      8'h20
`define LXS_ADDR_H1_MASK      8'h21
`define LXS_ADDR_H2_STAT      8'h22
`define LXS_ADDR_H2_MASK      8'h23
`define LXS_ADDR_LINK_STAT    8'h24
`define LXS_ADDR_LINK_MASK    8'h25
`define LXS_ADDR_EVT_INFO     8'h2d
`define LXS_ADDR_H1_INFO      8'h2e
`define LXS_ADDR_H2_INFO      8'h2f

// Reset value of every register
`define LXS_RST_BYTE          8'h00

// Elastic-store status bits
`define LXS_TX_FULL_BIT       5
`define LXS_TX_EMPTY_BIT      4
`define LXS_TX_SLIP_BIT       3
`define LXS_RX_FULL_BIT       2
`define LXS_RX_EMPTY_BIT      1
`define LXS_RX_SLIP_BIT       0

// Data-link status bits
`define LXS_CODE_CLR_BIT      5
`define LXS_LINK_ABORT_BIT    4
`define LXS_LINK_RXFULL_BIT   3
`define LXS_LINK_TXEMPTY_BIT  2
`define LXS_LINK_MATCH_BIT    1
`define LXS_CODE_CHG_BIT      0

// FIFO depth and bit-run counts
`define LXS_FIFO_DEPTH        8'h80
`define LXS_FIFO_NONE         8'h00
`define LXS_HDLC_ABORT_ONES   3'h7
`define LXS_LINK_ABORT_ONES   4'h8
`define LXS_CODE_CLR_BITS     5'h1e

// Packet status codes
`define LXS_PS_BUSY           3'h0
`define LXS_PS_GOOD           3'h1
`define LXS_PS_CRC_ERR        3'h2
`define LXS_PS_ABORT          3'h3
`define LXS_PS_OVERRUN        3'h4

`endif

// ==== shared/lxs_pkg.sv ====
// Purpose: Types carried between the status block and its neighbours
// Assumes: All signals synchronous to clock_i
// Notes:   Pulses are one cycle wide
package lxs_pkg;

    // Elastic store slip pulses
    typedef struct packed {
        logic tx_del;      // Tx store overfilled, frame dropped
        logic tx_rep;      // Tx store ran dry, frame repeated
        logic rx_del;
        logic rx_rep;
    } lxs_store_s;

    // One HDLC controller's event and fill inputs
    typedef struct packed {
        logic [7:0] rx_count;     // Bytes held in receive FIFO
        logic [7:0] tx_count;     // Bytes held in transmit FIFO
        logic [7:0] rx_high_mark_setting;
        logic [7:0] tx_low_mark_setting;
        logic       tx_msg_done;  // Transmitter finished a message
        logic       tx_end_given; // Message-end indication written
        logic       tx_need;      // Transmitter wants next byte
        logic       rx_start;     // Opening byte detected
        logic       rx_crc_good;
        logic       rx_crc_bad;
        logic       rx_bit_en;
        logic       rx_bit;
        logic       rx_wr;        // Receiver pushes a byte
        logic       rx_rd;        // Host pops a byte
        logic       rx_rd_last;   // Popped byte closes a packet
        logic       rx_next_first;// Next readable byte opens a message
    } lxs_hdlc_s;

    // Facility data link inputs
    typedef struct packed {
        logic       bit_en;
        logic       bit_val;
        logic       rx_byte_load;  // Receive buffer filled
        logic [7:0] link_rx_byte;
        logic [7:0] link_match_value_a;
        logic [7:0] link_match_value_b;
        logic       tx_byte_taken; // Transmit buffer drained
        logic       code_change;   // New valid code seen
    } lxs_link_s;

    // Per-controller state
    typedef struct packed {
        logic [2:0] evt;       // Message end, packet end, packet start
        logic [3:0] pend;      // Rising-edge latches of conditions
        logic [3:0] cond_prev;
        logic [2:0] ones;
        logic       in_pkt;
        logic       ended;
        logic [2:0] end_code;
        logic [2:0] pkt_status;
        logic       in_msg;
        logic       first_prev;
        logic [7:0] mask;
    } lxs_hctl_s;

    // Whole block state
    typedef struct packed {
        logic [7:0]      store_stat;
        logic [7:0]      store_mask;
        lxs_hctl_s [1:0] h;
        logic [3:0]      info_evt;
        logic [7:0]      link_stat;
        logic [7:0]      link_mask;
        logic [3:0]      link_ones;
        logic [4:0]      link_bits;
        logic [7:0]      rdata;
        logic            irq;
        logic [1:0]      tx_abort;
    } lxs_state_s;

endpackage

// ==== verification/lxs_host_model.sv ====
// Purpose: Host processor model on the parallel register bus
// Assumes: Called 1 ns after a rising edge; strobes one cycle wide
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/10ps

module lxs_host_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] rdata_i,
    output logic            cs_o,
    output logic            rd_o,
    output logic            wr_o,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o
);
    // Idle bus from time zero
    initial begin
        cs_o = 1'b0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end

    // One access, then one idle edge so strobes never merge
    task automatic access(input logic rd, input logic [7:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        cs_o = 1'b1;
        rd_o = rd;
        wr_o = !rd;
        addr_o = a;
        wdata_o = d;
        @(posedge clock_i);
        #1;
        q = rdata_i;
        cs_o = 1'b0;
        rd_o = 1'b0;
        wr_o = 1'b0;
        addr_o = ~a;   // Stale values would hide decode faults
        wdata_o = ~d;
        @(posedge clock_i);
        #1;
    endtask
endmodule

// ==== verification/lxs_status_regs_assertions.sv ====
// Purpose: Port-level assertions for the status register block
// Assumes: One clock, synchronous active-high reset
// Notes:   Live bits are checked for controller one only
`timescale 1ns/10ps

module lxs_status_regs_assertions (
    input wire logic                     clock_i,
    input wire logic                     rst_i,
    input wire logic                     cs_i,
    input wire logic                     rd_i,
    input wire logic                     wr_i,
    input wire logic [7:0]               addr_i,
    input wire logic [7:0]               wdata_i,
    input wire lxs_pkg::lxs_store_s      store_i,
    input wire lxs_pkg::lxs_hdlc_s [1:0] hdlc_i,
    input wire lxs_pkg::lxs_link_s       link_i,
    input wire logic [7:0]               rdata_o,
    input wire logic                     irq_o,
    input wire logic [1:0]               tx_abort_o
);
    logic [3:0] cond_one;
    logic [2:0] info_one;
    logic       hit;

    // Expected live bits, worked out from the counts at the ports
    assign cond_one = {hdlc_i[0].rx_count > hdlc_i[0].rx_high_mark_setting,
                       hdlc_i[0].rx_count != 8'h00,
                       hdlc_i[0].tx_count < hdlc_i[0].tx_low_mark_setting,
                       hdlc_i[0].tx_count != 8'h80};
    assign info_one = {hdlc_i[0].tx_count == 8'h00,
                       hdlc_i[0].tx_count == 8'h80,
                       hdlc_i[0].rx_count == 8'h00};
    assign hit = link_i.rx_byte_load &&
                 (link_i.link_rx_byte == link_i.link_match_value_a ||
                  link_i.link_rx_byte == link_i.link_match_value_b);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // A read strobe taken at one offset
    sequence s_rd(logic [7:0] a);
        cs_i && rd_i && addr_i == a;
    endsequence

    property p_tx_full;
        store_i.tx_del ##1 s_rd(8'h1e) |=> rdata_o[5] && rdata_o[3];
    endproperty
    a_tx_full: assert property (p_tx_full) else $error("tx full");
    property p_store_clear;
        cs_i && rd_i && addr_i == 8'h1e && store_i == 4'h0
            ##1 store_i == 4'h0 ##1 s_rd(8'h1e) |=> rdata_o == 8'h00;
    endproperty
    a_store_clear: assert property (p_store_clear) else $error("clear");
    property p_msg_end;
        hdlc_i[0].tx_msg_done ##1 s_rd(8'h20) |=> rdata_o[6];
    endproperty
    a_msg_end: assert property (p_msg_end) else $error("msg end flag");
    property p_cond_live;
        s_rd(8'h20) |=> rdata_o[3:0] == $past(cond_one);
    endproperty
    a_cond_live: assert property (p_cond_live)
        else $error("cond bits");
    property p_info_live;
        s_rd(8'h2e) |=> rdata_o[5:3] == $past(info_one);
    endproperty
    a_info_live: assert property (p_info_live) else $error("info bits");
    property p_underrun;
        tx_abort_o[0] |-> $past(hdlc_i[0].tx_need) && $past(info_one[2]);
    endproperty
    a_underrun: assert property (p_underrun) else $error("bad abort");
    property p_match;
        hit ##1 s_rd(8'h24) |=> rdata_o[3] && rdata_o[1];
    endproperty
    a_match: assert property (p_match) else $error("match flag");
    property p_code_change;
        link_i.code_change ##1 s_rd(8'h24) |=> rdata_o[0];
    endproperty
    a_code_change: assert property (p_code_change) else $error("code");
endmodule

bind lxs_status_regs lxs_status_regs_assertions u_chk (
    .clock_i, .rst_i, .cs_i, .rd_i, .wr_i, .addr_i, .wdata_i, .store_i,
    .hdlc_i, .link_i, .rdata_o, .irq_o, .tx_abort_o);

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the status register block
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Register traffic goes through the host model
`timescale 1ns/10ps

module testbench;
    localparam logic [11:0] k_msg_done = 12'h800;
    localparam logic [11:0] k_need     = 12'h200;
    localparam logic [11:0] k_start    = 12'h100;
    localparam logic [11:0] k_crc_good = 12'h080;
    localparam logic [11:0] k_crc_bad  = 12'h040;
    localparam logic [11:0] k_bit1     = 12'h030;
    localparam logic [11:0] k_wr       = 12'h008;
    localparam logic [11:0] k_rd_last  = 12'h006;
    logic                     clock_i;
    logic                     rst_i;
    logic                     cs;
    logic                     rd;
    logic                     wr;
    logic [7:0]               addr;
    logic [7:0]               wdata;
    logic [7:0]               rdata;
    logic                     irq;
    logic [1:0]               tx_abort;
    lxs_pkg::lxs_store_s      store_in;
    lxs_pkg::lxs_hdlc_s [1:0] hdlc_in;
    lxs_pkg::lxs_link_s       link_in;
    int                       bad_count;
    int                       comparisons;

    lxs_status_regs DUT (.clock_i(clock_i), .rst_i(rst_i), .cs_i(cs),
        .rd_i(rd), .wr_i(wr), .addr_i(addr), .wdata_i(wdata),
        .store_i(store_in), .hdlc_i(hdlc_in), .link_i(link_in),
        .rdata_o(rdata), .irq_o(irq), .tx_abort_o(tx_abort));
    lxs_host_model host (.clock_i(clock_i), .rdata_i(rdata), .cs_o(cs),
        .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));

    // 10 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
        logic [7:0] q;
        host.access(1'b1, a, 8'h00, q);
        check(q, want);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.access(1'b0, a, d, q);
    endtask
    // Bounded wait on the interrupt; running out ends the run
    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 6 && irq !== lvl; i++) tick();
        check({7'h00, irq}, {7'h00, lvl});
        if (irq !== lvl) print_verdict();
    endtask
    // One-cycle pulse on the single-bit fields of a controller
    task automatic pulse_h(input int c, input logic [11:0] p);
        hdlc_in[c][11:0] = hdlc_in[c][11:0] | p;
        tick();
        hdlc_in[c][11:0] = hdlc_in[c][11:0] & ~p;
    endtask

    // Reset values, mask widths, read-only and unmapped places
    task automatic t_regs;
        logic [7:0] a [7] = '{8'h1e, 8'h1f, 8'h21, 8'h23, 8'h24, 8'h25, 8'h2d};
        logic [7:0] m [7] = '{8'h00, 8'h3f, 8'h7f, 8'h7f, 8'h00, 8'h3f, 8'h00};
        foreach (a[i]) rd_chk(a[i], 8'h00);
        foreach (a[i]) wr_reg(a[i], 8'hff);
        foreach (a[i]) rd_chk(a[i], m[i]);
        wr_reg(8'h30, 8'hff);
        rd_chk(8'h30, 8'h00);
        foreach (a[i]) wr_reg(a[i], 8'h00);
    endtask
    // Each slip kind sets its own bit and the slip bit; a read clears
    task automatic t_store;
        logic [7:0] want [4] = '{8'h03, 8'h05, 8'h18, 8'h28};
        for (int i = 0; i < 4; i++) begin
            store_in = lxs_pkg::lxs_store_s'(4'h1 << i);
            tick();
            store_in = 4'h0;
            rd_chk(8'h1e, want[i]);
            rd_chk(8'h1e, 8'h00);
        end
    endtask
    // Masked source stays quiet; enabled one raises the request
    task automatic t_mask;
        wr_reg(8'h1f, 8'h20);
        store_in.tx_rep = 1'b1;
        tick();
        store_in = 4'h0;
        tick(4);
        check({7'h00, irq}, 8'h00);
        store_in.tx_del = 1'b1;
        tick();
        store_in = 4'h0;
        wait_irq(1'b1);
        wr_reg(8'h1f, 8'h00);
        wait_irq(1'b0);
        rd_chk(8'h1e, 8'h38);
    endtask
    // Condition interrupts on the rising edge only
    task automatic t_rise;
        rd_chk(8'h22, 8'h01);
        wr_reg(8'h23, 8'h04);
        hdlc_in[1].rx_count = 8'h03;
        wait_irq(1'b1);
        rd_chk(8'h22, 8'h0d);
        wait_irq(1'b0);
        tick(4);
        check({7'h00, irq}, 8'h00);
        wr_reg(8'h23, 8'h00);
    endtask
    // Events, live bits and packet status of one controller
    task automatic t_hdlc(input int c);
        hdlc_in[c][43:12] = {8'h05, 8'h80, 8'h04, 8'h14};
        hdlc_in[c].rx_next_first = 1'b1;
        pulse_h(c, k_start);
        pulse_h(c, k_crc_good);
        pulse_h(c, k_rd_last | k_msg_done);
        rd_chk(8'h20 + 8'(2 * c), 8'h7c);
        rd_chk(8'h20 + 8'(2 * c), 8'h0c);
        rd_chk(8'h2e + 8'(c), 8'h11);
        rd_chk(8'h2d, 8'(1 << (2 * c)));
        hdlc_in[c] = '0;
    endtask
    // Crc error, abort after seven ones, overrun on a full FIFO
    task automatic t_end;
        logic [11:0] cause [3] = '{k_crc_bad, k_bit1, k_wr};
        logic [7:0]  want [3] = '{8'h2a, 8'h2b, 8'h24};
        foreach (cause[i]) begin
            hdlc_in[0].rx_count = (i == 2) ? 8'h80 : 8'h00;
            pulse_h(0, k_start);
            repeat (i == 1 ? 7 : 1) pulse_h(0, cause[i]);
            pulse_h(0, k_rd_last);
            rd_chk(8'h2e, want[i]);
        end
        rd_chk(8'h20, 8'h3d);
        hdlc_in[0] = '0;
    endtask
    // Transmit FIFO runs dry mid-message
    task automatic t_underrun(input int c);
        hdlc_in[c].tx_count = 8'h03;
        pulse_h(c, k_need);
        hdlc_in[c].tx_count = 8'h00;
        pulse_h(c, k_need);
        check({6'h00, tx_abort}, 8'(1 << c));
        rd_chk(8'h2d, 8'(2 << (2 * c)));
    endtask
    // Link abort, 30-bit clear window edge, match and buffer events
    task automatic t_link;
        logic [7:0] b [3] = '{8'h5a, 8'h7e, 8'h5b};
        logic [7:0] w [3] = '{8'h0a, 8'h0a, 8'h08};
        link_in.link_match_value_a = 8'h5a;
        link_in.link_match_value_b = 8'h7e;
        link_in.bit_en = 1'b1;
        link_in.bit_val = 1'b1;
        tick(8);
        link_in.bit_en = 1'b0;
        rd_chk(8'h24, 8'h10);
        link_in.bit_en = 1'b1;
        link_in.bit_val = 1'b0;
        tick(29);
        link_in.bit_en = 1'b0;
        rd_chk(8'h24, 8'h00);
        link_in.bit_en = 1'b1;
        tick();
        link_in.bit_en = 1'b0;
        rd_chk(8'h24, 8'h20);
        foreach (b[i]) begin
            link_in.link_rx_byte = b[i];
            link_in.rx_byte_load = 1'b1;
            tick();
            link_in.rx_byte_load = 1'b0;
            rd_chk(8'h24, w[i]);
        end
        link_in.tx_byte_taken = 1'b1;
        link_in.code_change = 1'b1;
        tick();
        link_in = '0;
        rd_chk(8'h24, 8'h05);
    endtask
    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        print_verdict();
    end

    // Main sequence
    initial begin
        bad_count = 0;
        comparisons = 0;
        rst_i = 1'b1;
        store_in = 4'h0;
        hdlc_in = '0;
        link_in = '0;
        repeat (20) @(posedge clock_i);
        #1;
        rst_i = 1'b0;
        tick();
        t_regs();
        t_store();
        t_mask();
        t_rise();
        t_hdlc(0);
        t_hdlc(1);
        t_end();
        t_underrun(0);
        t_underrun(1);
        t_link();
        print_verdict();
    end
endmodule
